// [cpmps_core.sv]
// program store, program counter, return stack, data space and flags
// assumes the decoder drives one action per cycle, synchronous to clock_i
// Contract
// - read-only 12-bit program store, 512 or 1K
// - pc increment past top wraps to zero
// - any reset loads pc with top address
// - 25 RAM bytes plus seven mapped registers
// - indirect port accesses location named by pointer
// - indirect through pointer zero reads zero
// - five pointer bits address; upper three read one
// - reset loads flag upper bits 00011
// - timer count cleared on reset
// - pc width 10 or 9; low byte mapped
// - goto loads bit 8; call, pcl clear it
// - two-entry hidden stack for call, return
// - overflow keeps two newest; underflow repeats level two
// - computed flags beat written flags; to, pd fixed
// - flag register layout, page bit writable
// - timeout flag set/cleared by its events
// - powerdown flag set/cleared by its events
// - zero flag reflects zero result
// - digit carry from bit 3, inverted borrow
// - carry is carry, inverted borrow, rotated bit
`timescale 1ns/1ps
`include "cpmps_regs.svh"

module cpmps_core #(
   parameter bit LARGE = 1'b1
) (
   // clock and reset
   input  wire logic                        clock_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        ce_i,
   // reset causes and power events
   input  wire logic                        soft_rst_i,
   input  wire logic                        wdt_cause_i,
   input  wire logic                        clr_wdt_i,
   input  wire logic                        sleep_i,
   // program store load port
   input  wire logic                        prog_we_i,
   input  wire logic [9:0]                  prog_addr_i,
   input  wire logic [11:0]                 prog_data_i,
   // program counter control
   input  wire cpmps_pkg::cpmps_pc_op_t     pc_op_i,
   input  wire logic [8:0]                  pc_target_i,
   output logic      [9:0]                  pc_o,
   output logic      [11:0]                 instr_o,
   // data space access
   input  wire logic [4:0]                  addr_i,
   input  wire logic                        rd_en_i,
   input  wire logic                        wr_en_i,
   input  wire logic [7:0]                  wdata_i,
   output logic      [7:0]                  rdata_o,
   // alu flag sources
   input  wire cpmps_pkg::cpmps_alu_op_t    alu_op_i,
   input  wire logic [7:0]                  alu_a_i,
   input  wire logic [7:0]                  alu_b_i,
   input  wire logic [7:0]                  alu_res_i,
   output logic      [7:0]                  flags_o,
   // peripheral registers
   input  wire logic                        tmr_tick_i,
   input  wire logic [3:0]                  port_a_pin_i,
   input  wire logic [7:0]                  port_b_pin_i,
   output logic      [3:0]                  port_a_latch_o,
   output logic      [7:0]                  port_b_latch_o,
   input  wire logic                        dir_a_we_i,
   input  wire logic                        dir_b_we_i,
   input  wire logic                        tcfg_we_i,
   output logic      [7:0]                  dir_a_o,
   output logic      [7:0]                  dir_b_o,
   output logic      [7:0]                  tcfg_o
);
   import cpmps_pkg::*;

   localparam int PC_W  = LARGE ? `CPMPS_PC_W_LARGE : `CPMPS_PC_W_SMALL;
   localparam int DEPTH = 1 << PC_W;
   localparam logic [PC_W-1:0] PC_TOP = {PC_W{1'b1}};
   // only the 512-word and 1K-word store sizes are served
   if (PC_W != `CPMPS_PC_W_LARGE && PC_W != `CPMPS_PC_W_SMALL) begin : g_chk
      $error("cpmps_core: unsupported program counter width");
   end
   logic [`CPMPS_INSTR_W-1:0] rom_q [DEPTH];
   logic [7:0]       ram_q [`CPMPS_RAM_BYTES];
   logic [PC_W-1:0]  pc_q, pc_d, pc_inc, stack_top;
   logic [11:0]      instr_q;
   logic [4:0]       ptr_q, ea, ram_idx, sum5;
   logic [7:0]       timer_q, dir_a_q, dir_b_q, tcfg_q;
   logic [7:0]       rdata_q, rd_d, pb_latch_q;
   logic [3:0]       pa_latch_q;
   logic             page_q, to_q, pd_q, z_q, dc_q, c_q;
   logic             wr_go, pcl_wr, z_new, dc_new, c_new;
   logic [8:0]       sum9;

   // program store: loaded by the programming port only, never by the cpu
   always_ff @(posedge clock_i)
      if (ce_i && prog_we_i) rom_q[prog_addr_i[PC_W-1:0]] <= prog_data_i;
   // fetch register follows the pc each cycle
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         instr_q <= 12'h000;
      end else if (ce_i) begin
         instr_q <= rom_q[pc_q];
      end
   end

   // effective address: the indirect port redirects through the pointer
   assign ea     = (addr_i == `CPMPS_ADDR_INDIRECT) ? ptr_q : addr_i;
   // a write that lands back on the indirect port has nowhere to go
   assign wr_go  = wr_en_i && (ea != `CPMPS_ADDR_INDIRECT);
   assign pcl_wr = wr_go && (ea == `CPMPS_ADDR_PCL);
   assign ram_idx = 5'(ea - `CPMPS_ADDR_RAM_LO);

   // natural overflow of the counter gives the wrap to zero
   assign pc_inc = pc_q + 1'b1;
   // next pc; a pcl write outranks the decoder's own action
   always_comb begin
      pc_d = pc_q;
      if (pcl_wr) begin
         pc_d = PC_W'({page_q, 1'b0, wdata_i});
      end else begin
         unique case (pc_op_i)
            CPMPS_PC_HOLD: pc_d = pc_q;
            CPMPS_PC_INC:  pc_d = pc_inc;
            CPMPS_PC_GOTO: pc_d = PC_W'({page_q, pc_target_i});
            CPMPS_PC_CALL: pc_d = PC_W'({page_q, 1'b0, pc_target_i[7:0]});
            CPMPS_PC_RET:  pc_d = stack_top;
            default:       pc_d = pc_q;
         endcase
      end
   end

   // program counter; every reset starts at the top word
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pc_q <= PC_TOP;
      end else if (ce_i) begin
         pc_q <= soft_rst_i ? PC_TOP : pc_d;
      end
   end

   // return stack holds the address after the call
   cpmps_ret_stack #(.W (PC_W)) u_stack (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .ce_i        (ce_i && !soft_rst_i && !pcl_wr),
      .push_i      (pc_op_i == CPMPS_PC_CALL),
      .pop_i       (pc_op_i == CPMPS_PC_RET),
      .push_data_i (pc_inc),
      .top_o       (stack_top)
   );
   // flag computation from the alu operands
   assign sum9 = (alu_op_i == CPMPS_ALU_SUB) ?
                 9'({1'b0, alu_a_i} + {1'b0, ~alu_b_i} + 9'h001) :
                 9'({1'b0, alu_a_i} + {1'b0, alu_b_i});
   assign sum5 = (alu_op_i == CPMPS_ALU_SUB) ?
                 5'({1'b0, alu_a_i[3:0]} + {1'b0, ~alu_b_i[3:0]} + 5'h01) :
                 5'({1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]});
   // a subtract through two's complement yields carry = not borrow
   always_comb begin
      z_new  = z_q;
      dc_new = dc_q;
      c_new  = c_q;
      unique case (alu_op_i)
         CPMPS_ALU_NONE: ;
         CPMPS_ALU_ADD, CPMPS_ALU_SUB: begin
            z_new  = (alu_res_i == 8'h00);
            dc_new = sum5[4];
            c_new  = sum9[8];
         end
         CPMPS_ALU_LOGIC: z_new = (alu_res_i == 8'h00);
         CPMPS_ALU_ROTL:  c_new = alu_a_i[7];
         CPMPS_ALU_ROTR:  c_new = alu_a_i[0];
         default: ;
      endcase
   end

   // arithmetic flags: a flag-setting instruction beats a direct write
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         z_q  <= 1'b0; // undefined in hardware, zero for determinism
         dc_q <= 1'b0;
         c_q  <= 1'b0;
      end else if (ce_i) begin
         if (alu_op_i != CPMPS_ALU_NONE) begin
            z_q  <= z_new;
            dc_q <= dc_new;
            c_q  <= c_new;
         end else if (wr_go && ea == `CPMPS_ADDR_FLAGS) begin
            z_q  <= wdata_i[`CPMPS_FLAG_ZERO];
            dc_q <= wdata_i[`CPMPS_FLAG_DCARRY];
            c_q  <= wdata_i[`CPMPS_FLAG_CARRY];
         end
      end
   end

   // page bit: cleared by every reset, otherwise software-owned
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         page_q <= 1'b0;
      end else if (ce_i) begin
         if (soft_rst_i) begin
            page_q <= 1'b0;
         end else if (wr_go && ea == `CPMPS_ADDR_FLAGS) begin
            page_q <= wdata_i[`CPMPS_FLAG_PAGE];
         end
      end
   end

   // timeout and powerdown flags move only on their hardware events
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         to_q <= 1'b1;
         pd_q <= 1'b1;
      end else if (ce_i) begin
         if (soft_rst_i && wdt_cause_i) begin
            to_q <= 1'b0;
         end else if (clr_wdt_i) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
         end else if (sleep_i) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
         end
      end
   end
   // pointer keeps only the implemented address bits
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ptr_q <= 5'h00;
      end else if (ce_i && wr_go && ea == `CPMPS_ADDR_POINTER) begin
         ptr_q <= wdata_i[4:0];
      end
   end
   // timer count; a software write takes priority over the tick
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer_q <= `CPMPS_RST_TIMER;
      end else if (ce_i) begin
         if (soft_rst_i) begin
            timer_q <= `CPMPS_RST_TIMER;
         end else if (wr_go && ea == `CPMPS_ADDR_TIMER) begin
            timer_q <= wdata_i;
         end else if (tmr_tick_i) begin
            timer_q <= timer_q + 8'h01;
         end
      end
   end
   // port output latches keep their value across a soft reset; rst_b_i clears them
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pa_latch_q <= 4'h0;
         pb_latch_q <= 8'h00;
      end else if (ce_i && wr_go) begin
         if (ea == `CPMPS_ADDR_PORT_A) pa_latch_q <= wdata_i[3:0];
         if (ea == `CPMPS_ADDR_PORT_B) pb_latch_q <= wdata_i;
      end
   end

   // write-only direction and timer configuration registers
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dir_a_q <= `CPMPS_RST_DIR;
         dir_b_q <= `CPMPS_RST_DIR;
         tcfg_q  <= `CPMPS_RST_TCFG;
      end else if (ce_i) begin
         if (soft_rst_i) begin
            dir_a_q <= `CPMPS_RST_DIR;
            dir_b_q <= `CPMPS_RST_DIR;
            tcfg_q  <= `CPMPS_RST_TCFG;
         end else begin
            if (dir_a_we_i) dir_a_q <= wdata_i;
            if (dir_b_we_i) dir_b_q <= wdata_i;
            if (tcfg_we_i)  tcfg_q  <= wdata_i;
         end
      end
   end
   // general purpose ram, no reset: contents are unknown at power-up
   always_ff @(posedge clock_i)
      if (ce_i && wr_go && ea >= `CPMPS_ADDR_RAM_LO)
         ram_q[ram_idx] <= wdata_i;
   // read multiplexer over the whole 32-byte space
   always_comb begin
      rd_d = 8'h00;
      unique case (ea)
         `CPMPS_ADDR_INDIRECT: rd_d = `CPMPS_INDIRECT_NULL;
         `CPMPS_ADDR_TIMER:    rd_d = timer_q;
         `CPMPS_ADDR_PCL:      rd_d = pc_q[7:0];
         `CPMPS_ADDR_FLAGS:    rd_d = flags_o;
         `CPMPS_ADDR_POINTER:  rd_d = {`CPMPS_RST_PTR_HI, ptr_q};
         `CPMPS_ADDR_PORT_A:   rd_d = {4'h0, port_a_pin_i};
         `CPMPS_ADDR_PORT_B:   rd_d = port_b_pin_i;
         default:              rd_d = ram_q[ram_idx];
      endcase
   end

   // read data registered, valid the cycle after rd_en_i
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= 8'h00;
      end else if (ce_i && rd_en_i) begin
         rdata_q <= rd_d;
      end
   end

   assign flags_o        = {2'b00, page_q, to_q, pd_q, z_q, dc_q, c_q};
   assign pc_o           = 10'(pc_q);
   assign instr_o        = instr_q;
   assign rdata_o        = rdata_q;
   assign port_a_latch_o = pa_latch_q;
   assign port_b_latch_o = pb_latch_q;
   assign dir_a_o        = dir_a_q;
   assign dir_b_o        = dir_b_q;
   assign tcfg_o         = tcfg_q;

   // checks on the observable behaviour
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_call;
      ce_i && !soft_rst_i && !pcl_wr && pc_op_i == CPMPS_PC_CALL;
   endsequence
   sequence s_ret;
      ce_i && !soft_rst_i && !pcl_wr && pc_op_i == CPMPS_PC_RET;
   endsequence
   sequence s_hold;
      ce_i && !soft_rst_i && !pcl_wr && pc_op_i == CPMPS_PC_HOLD;
   endsequence

   a_pc_wrap: assert property (
      ce_i && !soft_rst_i && !pcl_wr && pc_op_i == CPMPS_PC_INC &&
      pc_q == PC_TOP |=> pc_q == '0)
      else $error("pc did not wrap to zero");
   a_reset_vector: assert property (
      ce_i && soft_rst_i |=> pc_q == PC_TOP && !page_q)
      else $error("pc not at reset vector");
   a_indirect_null: assert property (
      ce_i && rd_en_i && addr_i == 5'h00 && ptr_q == 5'h00
      |=> rdata_o == 8'h00)
      else $error("indirect through zero read nonzero");
   a_pointer_ones: assert property (
      ce_i && rd_en_i && addr_i == `CPMPS_ADDR_POINTER
      |=> rdata_o[7:5] == 3'h7)
      else $error("pointer upper bits not ones");
   a_call_return: assert property (
      s_call ##1 s_hold ##1 s_ret |=> pc_q == $past(pc_q, 3) + 1'b1)
      else $error("return did not restore call address");
   a_call_clear8: assert property (
      s_call |=> pc_q[7:0] == $past(pc_target_i[7:0]) && pc_q[8] == 1'b0)
      else $error("call did not clear pc bit 8");
   a_flags_win: assert property (
      ce_i && alu_op_i == CPMPS_ALU_ADD && wr_go &&
      ea == `CPMPS_ADDR_FLAGS |=> z_q == $past(alu_res_i == 8'h00))
      else $error("written zero flag beat computed one");
   a_sleep_flags: assert property (
      ce_i && sleep_i && !clr_wdt_i && !soft_rst_i |=> !pd_q && to_q)
      else $error("power-down flags wrong after sleep");
   a_wdt_timeout: assert property (
      ce_i && soft_rst_i && wdt_cause_i |=> !to_q)
      else $error("timeout flag not cleared by watchdog");

endmodule // cpmps_core

// [cpmps_regs.svh]
// offsets, field positions, reset images and widths of the cpu data space
// assumes inclusion by the cpu memory block and its package users
`ifndef CPMPS_REGS_SVH
`define CPMPS_REGS_SVH

// data-space offsets
`define CPMPS_ADDR_INDIRECT   5'h00
`define CPMPS_ADDR_TIMER      5'h01
`define CPMPS_ADDR_PCL        5'h02
`define CPMPS_ADDR_FLAGS      5'h03
`define CPMPS_ADDR_POINTER    5'h04
`define CPMPS_ADDR_PORT_A     5'h05
`define CPMPS_ADDR_PORT_B     5'h06
`define CPMPS_ADDR_RAM_LO     5'h07
`define CPMPS_ADDR_RAM_HI     5'h1F
`define CPMPS_RAM_BYTES       25

// flag register bit positions
`define CPMPS_FLAG_PAGE       5
`define CPMPS_FLAG_TIMEOUT    4
`define CPMPS_FLAG_PDOWN      3
`define CPMPS_FLAG_ZERO       2
`define CPMPS_FLAG_DCARRY     1
`define CPMPS_FLAG_CARRY      0

// reset images
`define CPMPS_RST_TIMER       8'h00
`define CPMPS_RST_PTR_HI      3'h7
`define CPMPS_RST_DIR         8'hFF
`define CPMPS_RST_TCFG        8'h3F
`define CPMPS_INDIRECT_NULL   8'h00

// program store
`define CPMPS_INSTR_W         12
`define CPMPS_PC_W_SMALL      9
`define CPMPS_PC_W_LARGE      10

`endif

// [cpmps_pkg.sv]
// types shared by the cpu memory block and its decoder
// assumes nothing beyond a systemverilog compiler
package cpmps_pkg;

   // program counter action for this cycle
   typedef enum logic [2:0] {
      CPMPS_PC_HOLD,
      CPMPS_PC_INC,
      CPMPS_PC_GOTO,
      CPMPS_PC_CALL,
      CPMPS_PC_RET
   } cpmps_pc_op_t;

   // kind of alu operation whose flags are to be recorded
   typedef enum logic [2:0] {
      CPMPS_ALU_NONE,
      CPMPS_ALU_ADD,
      CPMPS_ALU_SUB,
      CPMPS_ALU_LOGIC,
      CPMPS_ALU_ROTL,
      CPMPS_ALU_ROTR
   } cpmps_alu_op_t;

endpackage

// [cpmps_ret_stack.sv]
// two-level return stack, as wide as the program counter
// assumes the caller never pushes and pops in the same cycle
`timescale 1ns/1ps

module cpmps_ret_stack #(
   parameter int W = 10
) (
   // clock and reset
   input  wire logic         clock_i,
   input  wire logic         rst_b_i,
   input  wire logic         ce_i,
   // stack operations
   input  wire logic         push_i,
   input  wire logic         pop_i,
   input  wire logic [W-1:0] push_data_i,
   output logic      [W-1:0] top_o
);

   logic [W-1:0] lvl1_q;
   logic [W-1:0] lvl2_q;

   // oldest entry falls off on overflow; level 2 is kept on a pop so
   // extra returns keep delivering it
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lvl1_q <= '0;
         lvl2_q <= '0;
      end else if (ce_i && push_i) begin
         lvl1_q <= push_data_i;
         lvl2_q <= lvl1_q;
      end else if (ce_i && pop_i) begin
         lvl1_q <= lvl2_q;
      end
   end

   assign top_o = lvl1_q;

endmodule // cpmps_ret_stack

// [cpmps_dec_model.sv]
// decoder and alu stand-in facing the cpu memory block
// assumes the core takes each request on the rising edge of clock_i
`timescale 1ns/1ps

module cpmps_dec_model (
   // clock
   input  wire logic                clock_i,
   // requests towards the core
   output cpmps_pkg::cpmps_pc_op_t  pc_op_o,
   output cpmps_pkg::cpmps_alu_op_t alu_op_o,
   output logic [8:0]               pc_target_o,
   output logic                     rd_en_o,
   output logic                     wr_en_o,
   output logic [4:0]               addr_o,
   output logic [7:0]               wdata_o,
   output logic [7:0]               alu_a_o,
   output logic [7:0]               alu_b_o,
   output logic [7:0]               alu_res_o
);
   import cpmps_pkg::*;

   // back to idle; unqualified lines wander so stale values never match
   task automatic idle();
      pc_op_o = CPMPS_PC_HOLD;
      alu_op_o = CPMPS_ALU_NONE;
      rd_en_o = 1'h0;
      wr_en_o = 1'h0;
      {pc_target_o, addr_o, wdata_o} = ~{pc_target_o, addr_o, wdata_o};
      {alu_a_o, alu_b_o, alu_res_o} = ~{alu_a_o, alu_b_o, alu_res_o};
   endtask

   initial begin
      {pc_target_o, addr_o, wdata_o, alu_a_o, alu_b_o, alu_res_o} = '0;
      idle();
   end

   // one instruction cycle: driven after an edge, held to the taking edge
   // page bit is set by the caller before a crossing branch
   // flag writes that race alu flags are only made on purpose
   task automatic cyc(input cpmps_pc_op_t op, input logic [8:0] tgt,
                      input logic we, input logic rd, input logic [4:0] a,
                      input logic [7:0] d, input cpmps_alu_op_t aop,
                      input logic [7:0] x, input logic [7:0] y,
                      input logic [7:0] r);
      @(posedge clock_i);
      #1;
      pc_op_o = op;
      pc_target_o = tgt;
      wr_en_o = we;
      rd_en_o = rd;
      addr_o = a;
      wdata_o = d;
      alu_op_o = aop;
      {alu_a_o, alu_b_o, alu_res_o} = {x, y, r};
      @(posedge clock_i);
      #1;
      idle();
   endtask
endmodule // cpmps_dec_model

// [tb.sv]
// self-checking bench for the cpu memory, pc, stack and flag block
// assumes the decoder stand-in drives data, pc and alu requests
`timescale 1ns/1ps

module tb;
   import cpmps_pkg::*;

   // clock, reset and bench strobes {tick, soft, cause, clr, sleep}
   logic          clock_i = 1'h0;
   logic          rst_b_i;
   logic [4:0]    ev;
   logic [2:0]    side;
   logic          prog_we;
   logic [9:0]    prog_addr;
   logic [11:0]   prog_data;
   // decoder stand-in requests
   cpmps_pc_op_t  pc_op;
   cpmps_alu_op_t alu_op;
   logic [8:0]    pc_target;
   logic          rd_en;
   logic          wr_en;
   logic [4:0]    addr;
   logic [7:0]    wdata, alu_a, alu_b, alu_res;
   // core outputs
   logic [9:0]    pc;
   logic [11:0]   instr;
   logic [7:0]    rdata, flags, dir_a, dir_b, tcfg, pb_latch;
   logic [3:0]    pa_latch;
   // bookkeeping
   int            bad_count = 0;
   int            total_checks = 0;
   int            cycles = 0;
   logic [21:0]   r;
   logic [29:0]   ar;
   logic [12:0]   er;

   // data rows {write, addr, wdata, expected read}
   logic [21:0] drow [18] = '{
      {1'h0, 5'h04, 8'h00, 8'hE0}, {1'h0, 5'h01, 8'h00, 8'h00},
      {1'h1, 5'h07, 8'h5A, 8'h5A}, {1'h1, 5'h1F, 8'hA5, 8'hA5},
      {1'h1, 5'h04, 8'hFF, 8'hFF}, {1'h1, 5'h04, 8'h0A, 8'hEA},
      {1'h1, 5'h00, 8'h77, 8'h77}, {1'h0, 5'h0A, 8'h00, 8'h77},
      {1'h1, 5'h0A, 8'h11, 8'h11}, {1'h0, 5'h00, 8'h00, 8'h11},
      {1'h1, 5'h01, 8'h3C, 8'h3C}, {1'h1, 5'h05, 8'h0F, 8'h05},
      {1'h1, 5'h06, 8'h96, 8'hC3}, {1'h1, 5'h03, 8'hFF, 8'h3F},
      {1'h1, 5'h03, 8'hC0, 8'h18}, {1'h1, 5'h04, 8'h00, 8'hE0},
      {1'h1, 5'h00, 8'h99, 8'h00}, {1'h0, 5'h07, 8'h00, 8'h5A}
   };
   // alu rows {op, a, b, result, expected z dc c}
   logic [29:0] arow [7] = '{
      {CPMPS_ALU_ADD, 8'h08, 8'h08, 8'h10, 3'h2},
      {CPMPS_ALU_ADD, 8'hFF, 8'h01, 8'h00, 3'h7},
      {CPMPS_ALU_SUB, 8'h00, 8'h01, 8'hFF, 3'h0},
      {CPMPS_ALU_SUB, 8'h05, 8'h05, 8'h00, 3'h7},
      {CPMPS_ALU_LOGIC, 8'h00, 8'h00, 8'h3C, 3'h3},
      {CPMPS_ALU_ROTR, 8'h02, 8'h00, 8'h01, 3'h2},
      {CPMPS_ALU_ROTL, 8'h80, 8'h00, 8'h01, 3'h3}
   };
   // pc rows {op, target, expected pc} with page bit set
   logic [21:0] prow [8] = '{
      {CPMPS_PC_GOTO, 9'h155, 10'h355}, {CPMPS_PC_CALL, 9'h1A0, 10'h2A0},
      {CPMPS_PC_CALL, 9'h130, 10'h230}, {CPMPS_PC_CALL, 9'h140, 10'h240},
      {CPMPS_PC_RET, 9'h000, 10'h231}, {CPMPS_PC_RET, 9'h000, 10'h2A1},
      {CPMPS_PC_RET, 9'h000, 10'h2A1}, {CPMPS_PC_INC, 9'h000, 10'h2A2}
   };
   // power event rows {strobes, expected flag image}
   logic [12:0] erow [6] = '{
      {5'h01, 8'h37}, {5'h02, 8'h3F}, {5'h01, 8'h37},
      {5'h0C, 8'h07}, {5'h02, 8'h1F}, {5'h08, 8'h1F}
   };

   always #20 clock_i = ~clock_i;

   cpmps_core #(.LARGE(1'b1)) dut_u (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(1'h1),
      .soft_rst_i(ev[3]), .wdt_cause_i(ev[2]), .clr_wdt_i(ev[1]),
      .sleep_i(ev[0]), .prog_we_i(prog_we), .prog_addr_i(prog_addr),
      .prog_data_i(prog_data), .pc_op_i(pc_op), .pc_target_i(pc_target),
      .pc_o(pc), .instr_o(instr), .addr_i(addr), .rd_en_i(rd_en),
      .wr_en_i(wr_en), .wdata_i(wdata), .rdata_o(rdata),
      .alu_op_i(alu_op), .alu_a_i(alu_a), .alu_b_i(alu_b),
      .alu_res_i(alu_res), .flags_o(flags), .tmr_tick_i(ev[4]),
      .port_a_pin_i(4'h5), .port_b_pin_i(8'hC3), .port_a_latch_o(pa_latch),
      .port_b_latch_o(pb_latch), .dir_a_we_i(side[0]), .dir_b_we_i(side[1]),
      .tcfg_we_i(side[2]), .dir_a_o(dir_a), .dir_b_o(dir_b), .tcfg_o(tcfg));

   cpmps_dec_model partner_u (
      .clock_i(clock_i), .pc_op_o(pc_op), .alu_op_o(alu_op),
      .pc_target_o(pc_target), .rd_en_o(rd_en), .wr_en_o(wr_en),
      .addr_o(addr), .wdata_o(wdata), .alu_a_o(alu_a), .alu_b_o(alu_b),
      .alu_res_o(alu_res));

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one data access with no pc or alu activity
   task automatic acc(input logic we, input logic [4:0] a,
                      input logic [7:0] d);
      partner_u.cyc(CPMPS_PC_HOLD, 9'h000, we, !we, a, d, CPMPS_ALU_NONE,
                    8'h00, 8'h00, 8'h00);
   endtask

   task automatic pulse(input logic [4:0] v);
      @(posedge clock_i);
      #1 ev = v;
      @(posedge clock_i);
      #1 ev = 5'h00;
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // hang guard, far above the roughly 130 cycles the run needs
   always @(posedge clock_i) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         end_sim();
      end
   end

   initial begin
      rst_b_i = 1'h0;
      ev = 5'h00;
      side = 3'h0;
      prog_we = 1'h0;
      prog_addr = 10'h000;
      prog_data = 12'hA5C;
      repeat (3) @(posedge clock_i);
      #1 rst_b_i = 1'h1;
      chk(12'(pc), 12'h3FF);
      chk(12'(flags), 12'h018);
      chk({dir_b[3:0], tcfg}, 12'hF3F);
      chk({dir_a, 4'h0}, 12'hFF0);
      // load one word at 000, then step over the top address
      @(posedge clock_i);
      #1 prog_we = 1'h1;
      @(posedge clock_i);
      #1 prog_we = 1'h0;
      partner_u.cyc(CPMPS_PC_INC, 9'h000, 1'h0, 1'h0, 5'h00, 8'h00,
                    CPMPS_ALU_NONE, 8'h00, 8'h00, 8'h00);
      chk(12'(pc), 12'h000);
      @(posedge clock_i);
      #1 chk(instr, 12'hA5C);
      foreach (drow[i]) begin
         r = drow[i];
         if (r[21]) acc(1'h1, r[20:16], r[15:8]);
         acc(1'h0, r[20:16], 8'h00);
         chk(12'(rdata), 12'(r[7:0]));
      end
      chk({pa_latch, pb_latch}, 12'hF96);
      foreach (arow[i]) begin
         ar = arow[i];
         partner_u.cyc(CPMPS_PC_HOLD, 9'h000, 1'h0, 1'h0, 5'h00, 8'h00,
                       cpmps_alu_op_t'(ar[29:27]), ar[26:19], ar[18:11],
                       ar[10:3]);
         chk(12'(flags[2:0]), 12'(ar[2:0]));
      end
      // flag write racing an add: page lands, computed flags win
      partner_u.cyc(CPMPS_PC_HOLD, 9'h000, 1'h1, 1'h0, 5'h03, 8'h20,
                    CPMPS_ALU_ADD, 8'hFF, 8'h01, 8'h00);
      chk(12'(flags), 12'h03F);
      foreach (prow[i]) begin
         r = prow[i];
         partner_u.cyc(cpmps_pc_op_t'(r[21:19]), r[18:10], 1'h0, 1'h0,
                       5'h00, 8'h00, CPMPS_ALU_NONE, 8'h00, 8'h00, 8'h00);
         chk(12'(pc), 12'(r[9:0]));
      end
      acc(1'h1, 5'h02, 8'h33);
      chk(12'(pc), 12'h233);
      acc(1'h0, 5'h02, 8'h00);
      chk(12'(rdata), 12'h033);
      // side registers take the wdata lines on their strobes
      fork
         partner_u.cyc(CPMPS_PC_HOLD, 9'h000, 1'h0, 1'h0, 5'h00, 8'h55,
                       CPMPS_ALU_NONE, 8'h00, 8'h00, 8'h00);
         begin
            @(posedge clock_i);
            #1 side = 3'h7;
            @(posedge clock_i);
            #1 side = 3'h0;
         end
      join
      chk({dir_a[3:0], dir_b[3:0], tcfg[3:0]}, 12'h555);
      foreach (erow[i]) begin
         er = erow[i];
         pulse(er[12:8]);
         chk(12'(flags), 12'(er[7:0]));
      end
      chk(12'(pc), 12'h3FF);
      chk({dir_a[3:0], dir_b[3:0], tcfg[7:4]}, 12'hFF3);
      acc(1'h0, 5'h01, 8'h00);
      chk(12'(rdata), 12'h000);
      pulse(5'h10);
      acc(1'h0, 5'h01, 8'h00);
      chk(12'(rdata), 12'h001);
      end_sim();
   end
endmodule // tb
